//--- verilog/dcw_pkg.sv
// Purpose: Shared constants and carriers for the control word decoder
// Assumes: 16-bit primary and secondary control words, one update clock
// Notes:   Bit positions and telegram numbers are named here only
package dcw_pkg;

  // ==========================================================
  // Telegram numbers
  // ==========================================================
  localparam logic [7:0] TG_1   = 8'h01;
  localparam logic [7:0] TG_2   = 8'h02;
  localparam logic [7:0] TG_3   = 8'h03;
  localparam logic [7:0] TG_5   = 8'h05;
  localparam logic [7:0] TG_7   = 8'h07;
  localparam logic [7:0] TG_9   = 8'h09;
  localparam logic [7:0] TG_102 = 8'h66;
  localparam logic [7:0] TG_105 = 8'h69;
  localparam logic [7:0] TG_110 = 8'h6e;
  localparam logic [7:0] TG_111 = 8'h6f;

  // ==========================================================
  // Primary word bit positions
  // ==========================================================
  localparam int P_ON      = 0;
  localparam int P_NOCOAST = 1;
  localparam int P_NOQUICK = 2;
  localparam int P_OPEN    = 3;
  localparam int P_B4      = 4;
  localparam int P_B5      = 5;
  localparam int P_B6      = 6;
  localparam int P_ACK     = 7;
  localparam int P_JOG1    = 8;
  localparam int P_JOG2    = 9;
  localparam int P_CTRL    = 10;
  localparam int P_B11     = 11;
  localparam int P_BRAKE   = 12;
  localparam int P_TORQUE  = 14;

  // ==========================================================
  // Secondary word bit positions
  // ==========================================================
  localparam int S_BYPASS  = 4;
  localparam int S_INTINH  = 6;
  localparam int S_ENDSTOP = 8;
  localparam int S_SOL_LO  = 12;
  localparam int S_SOL_HI  = 15;

  // Configuration option bit that gates basic-group bit 11 and bypass
  localparam int CFG_EN    = 0;

  // ==========================================================
  // Types
  // ==========================================================
  // Telegram group, one-hot
  typedef enum logic [3:0] {
    DCW_GRP_NONE = 4'b0001,
    DCW_GRP_BAS  = 4'b0010,
    DCW_GRP_TRQ  = 4'b0100,
    DCW_GRP_POS  = 4'b1000
  } dcw_grp_t;

  // Decoded commands
  typedef struct packed {
    logic       pulse_allow;   // All enables present
    logic       ramp_stop;     // Brake on ramp generator
    logic       coast_stop;    // Immediate pulse suppression
    logic       quick_stop;    // Brake on quick-stop ramp
    logic       op_inhibit;    // Operation inhibited
    logic       switch_inhibit;// Switching on inhibited
    logic       rfg_out_zero;  // Ramp output forced to zero
    logic       rfg_freeze;    // Ramp output held
    logic       rfg_in_zero;   // Ramp input forced to zero
    logic       fault_ack;     // Acknowledge faults
    logic       sp_invert;     // Setpoint inversion
    logic       rfg_active;    // Ramp generator active flag
    logic       brake_open;    // Open holding brake
    logic       torque_mode;   // 1 torque, 0 speed control
    logic       rfg_bypass;    // Bypass ramp generator
    logic       int_inhibit;   // Speed integrator inhibit
    logic       task_reject;   // Reject traversing task
    logic       inter_stop;    // Intermediate stop
    logic       jog1;          // Jog 1 source
    logic       jog2;          // Jog 2 source
    logic       ref_start;     // Referencing running
    logic       endstop;       // Traverse to fixed endstop
    logic       in_control;    // Controller has control
    logic [3:0] sign_of_life;  // Master sign-of-life
  } dcw_cmd_t;

endpackage

//--- verilog/dcw_group.sv
// Purpose: Map a telegram number to its group and secondary word flag
// Assumes: Telegram number is stable within a cycle
// Notes:   Purely combinational lookup
`timescale 1ns/1ps
module dcw_group (
  input  wire logic [7:0]       telegram,
  output dcw_pkg::dcw_grp_t     grp,
  output logic                  has_sec,
  output logic                  no_b456
);

  // ==========================================================
  // Group lookup
  // ==========================================================
  // Group and options per telegram
  always_comb begin
    grp     = dcw_pkg::DCW_GRP_NONE;
    has_sec = 1'b0;
    no_b456 = 1'b0;
    case (telegram)
      dcw_pkg::TG_1:   grp = dcw_pkg::DCW_GRP_BAS;
      dcw_pkg::TG_2,
      dcw_pkg::TG_3: begin
        grp     = dcw_pkg::DCW_GRP_BAS;
        has_sec = 1'b1;
      end
      dcw_pkg::TG_5: begin
        grp     = dcw_pkg::DCW_GRP_BAS;
        has_sec = 1'b1;
        no_b456 = 1'b1;
      end
      dcw_pkg::TG_102: begin
        grp     = dcw_pkg::DCW_GRP_TRQ;
        has_sec = 1'b1;
      end
      dcw_pkg::TG_105: begin
        grp     = dcw_pkg::DCW_GRP_TRQ;
        has_sec = 1'b1;
        no_b456 = 1'b1;
      end
      dcw_pkg::TG_7:   grp = dcw_pkg::DCW_GRP_POS;
      dcw_pkg::TG_9,
      dcw_pkg::TG_110,
      dcw_pkg::TG_111: begin
        grp     = dcw_pkg::DCW_GRP_POS;
        has_sec = 1'b1;
      end
      default: grp = dcw_pkg::DCW_GRP_NONE;
    endcase
  end

endmodule // dcw_group

//--- verilog/dcw_decoder.sv
// Purpose: Decode primary and secondary control words into commands
// Assumes: Words arrive on clk with a one-cycle update strobe
// Notes:   Outputs are registered; one cycle after the strobe
//
// Summary of operation
// - Telegram number picks bit map group
// - Bit0 low: ramp stop, then ready state
// - Bit1 low: coast stop, inhibit switch on
// - Bit2 low: quick-stop ramp, inhibit switch on
// - Bit3 is operation enable
// - Speed groups: bit4 low zeroes ramp output
// - Speed groups: bit5 low freezes ramp
// - Speed groups: bit6 low zeroes ramp input
// - Bit7 requests fault acknowledge
// - Bit10 low: ignore controller commands
// - Telegrams 5, 105 ignore bits 4-6
// - Basic group: bit11 inverts setpoint, option-gated
// - Torque group: bit11 ramp active, bit12 brake
// - Torque group: bit14 selects torque control
// - Torque group: secondary bit4 bypass, option-gated
// - Torque group: secondary bit6 integrator inhibit
// - Positioning: bit4 low rejects traversing task
// - Positioning: bit5 low intermediate stop
// - Positioning: bits 8, 9 jog sources
// - Positioning: bit11 starts referencing
// - Secondary bit8 traverse to fixed endstop
// - Secondary bits 12-15 master sign-of-life
`timescale 1ns/1ps
module dcw_decoder (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             word_valid,
  input  wire logic [15:0]      primary_control_word,
  input  wire logic [15:0]      secondary_control_word,
  input  wire logic [7:0]       telegram,
  input  wire logic [15:0]      configuration_option_parameter,
  output dcw_pkg::dcw_cmd_t     cmd,
  output logic                  sol_error
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    dcw_pkg::dcw_cmd_t cmd;     // Decoded commands
    logic              sol_err; // Sign-of-life skipped
    logic              sol_seen;// Sign-of-life reference valid
  } dcw_state_t;

  dcw_state_t        st_q;      // Registered state
  dcw_state_t        st_d;      // Next state
  dcw_pkg::dcw_grp_t grp;       // Active group
  logic              has_sec;   // Secondary word present
  logic              no_b456;   // Bits 4 to 6 disabled

  // Safe command set: pulses blocked, switching on inhibited
  localparam dcw_pkg::dcw_cmd_t CMD_RESET = '{
    ramp_stop: 1'b1, coast_stop: 1'b1, switch_inhibit: 1'b1,
    op_inhibit: 1'b1, rfg_out_zero: 1'b1, rfg_in_zero: 1'b1,
    task_reject: 1'b1, inter_stop: 1'b1, default: 1'b0};

  // ==========================================================
  // Group lookup
  // ==========================================================
  dcw_group i_dcw_group (
    .telegram (telegram),
    .grp      (grp),
    .has_sec  (has_sec),
    .no_b456  (no_b456)
  );

  // ==========================================================
  // Next-state decode
  // ==========================================================
  // Decode words on each update strobe
  always_comb begin
    logic [15:0] p;
    logic [15:0] s;
    logic        cfg;
    logic        spd;
    logic [3:0]  sol;
    p   = primary_control_word;
    s   = secondary_control_word;
    cfg = configuration_option_parameter[dcw_pkg::CFG_EN];
    spd = (grp == dcw_pkg::DCW_GRP_BAS) || (grp == dcw_pkg::DCW_GRP_TRQ);
    sol = s[dcw_pkg::S_SOL_HI:dcw_pkg::S_SOL_LO];
    st_d = st_q;
    // Reserved bits are never read below
    if (word_valid && grp != dcw_pkg::DCW_GRP_NONE) begin
      if (!p[dcw_pkg::P_CTRL]) begin
        // Controller not in control: commands ignored
        st_d.cmd.in_control = 1'b0;
      end else begin
        st_d.cmd = '0;
        st_d.cmd.in_control = 1'b1;
        // Stop modes, common to every group
        st_d.cmd.ramp_stop  = ~p[dcw_pkg::P_ON];
        st_d.cmd.coast_stop = ~p[dcw_pkg::P_NOCOAST];
        st_d.cmd.quick_stop = ~p[dcw_pkg::P_NOQUICK];
        st_d.cmd.op_inhibit = ~p[dcw_pkg::P_OPEN];
        st_d.cmd.switch_inhibit = ~p[dcw_pkg::P_NOCOAST]
                                | ~p[dcw_pkg::P_NOQUICK];
        st_d.cmd.pulse_allow = p[dcw_pkg::P_ON]
                             & p[dcw_pkg::P_NOCOAST]
                             & p[dcw_pkg::P_NOQUICK]
                             & p[dcw_pkg::P_OPEN];
        st_d.cmd.fault_ack  = p[dcw_pkg::P_ACK];
        // Ramp generator bits, speed groups only
        if (spd && !no_b456) begin
          st_d.cmd.rfg_out_zero = ~p[dcw_pkg::P_B4];
          st_d.cmd.rfg_freeze   = ~p[dcw_pkg::P_B5];
          st_d.cmd.rfg_in_zero  = ~p[dcw_pkg::P_B6];
        end
        case (grp)
          dcw_pkg::DCW_GRP_BAS: begin
            st_d.cmd.sp_invert = cfg & p[dcw_pkg::P_B11];
          end
          dcw_pkg::DCW_GRP_TRQ: begin
            st_d.cmd.rfg_active  = p[dcw_pkg::P_B11];
            st_d.cmd.brake_open  = p[dcw_pkg::P_BRAKE];
            st_d.cmd.torque_mode = p[dcw_pkg::P_TORQUE];
            st_d.cmd.rfg_bypass  = cfg & s[dcw_pkg::S_BYPASS];
            st_d.cmd.int_inhibit = s[dcw_pkg::S_INTINH];
          end
          dcw_pkg::DCW_GRP_POS: begin
            st_d.cmd.task_reject = ~p[dcw_pkg::P_B4];
            st_d.cmd.inter_stop  = ~p[dcw_pkg::P_B5];
            st_d.cmd.jog1        = p[dcw_pkg::P_JOG1];
            st_d.cmd.jog2        = p[dcw_pkg::P_JOG2];
            st_d.cmd.ref_start   = p[dcw_pkg::P_B11];
          end
          default: st_d.cmd.in_control = 1'b1;
        endcase
        if (has_sec) begin
          st_d.cmd.endstop      = s[dcw_pkg::S_ENDSTOP];
          st_d.cmd.sign_of_life = sol;
          // Flag a lost update when the count does not step by one
          st_d.sol_err  = st_q.sol_seen &&
                          (sol != st_q.cmd.sign_of_life + 4'h1);
          st_d.sol_seen = 1'b1;
        end else begin
          st_d.sol_err  = 1'b0;
          st_d.sol_seen = 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Registers the whole state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.cmd      <= CMD_RESET;
      st_q.sol_err  <= 1'b0;
      st_q.sol_seen <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign cmd       = st_q.cmd;
  assign sol_error = st_q.sol_err;

endmodule // dcw_decoder

//--- verif/dcw_decoder_chk.sv
// Purpose: Port assertions for the control word decoder
// Assumes: One clock, asynchronous active-low reset
// Notes:   Taken inputs are registered so results meet their causes
`timescale 1ns/1ps
module dcw_decoder_chk (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         word_valid,
  input  wire logic [15:0]  primary_control_word,
  input  wire logic [15:0]  secondary_control_word,
  input  wire logic [7:0]   telegram,
  input  wire logic [15:0]  configuration_option_parameter,
  input  dcw_pkg::dcw_cmd_t cmd,
  input  wire logic         sol_error
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  logic        bas, trq, pos, sec, kn, n456; // Group of the telegram
  logic        vq, bq, tq, oq, hq, nq, cq;   // Taken update and group
  logic [15:0] pq, sq;                       // Taken words
  assign bas  = telegram inside {8'h01, 8'h02, 8'h03, 8'h05};
  assign trq  = telegram inside {8'h66, 8'h69};
  assign pos  = telegram inside {8'h07, 8'h09, 8'h6e, 8'h6f};
  assign kn   = bas || trq || pos;
  assign sec  = kn && !(telegram inside {8'h01, 8'h07});
  assign n456 = telegram inside {8'h05, 8'h69};
  // Capture what the decoder takes at each edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {vq, bq, tq, oq, hq, nq, cq, pq, sq} <= '0;
    end else begin
      {vq, bq, tq, oq, hq, nq, cq, pq, sq} <= {word_valid && kn &&
        primary_control_word[10], bas, trq, pos, sec, n456,
        configuration_option_parameter[0], primary_control_word,
        secondary_control_word};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Properties
  // ==========================================================
  property p_stop;
    vq |-> cmd.ramp_stop == !pq[0] && cmd.coast_stop == !pq[1] &&
      cmd.quick_stop == !pq[2] && cmd.switch_inhibit == !(pq[1] && pq[2]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_en;
    vq |-> cmd.pulse_allow == &pq[3:0] && cmd.op_inhibit == !pq[3] &&
      cmd.fault_ack == pq[7];
  endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_rfg;
    vq && (bq || tq) |-> {cmd.rfg_in_zero, cmd.rfg_freeze,
      cmd.rfg_out_zero} == (nq ? 3'h0 : ~pq[6:4]);
  endproperty
  a_rfg: assert property (p_rfg) else $error("ramp");
  property p_hold;
    word_valid && kn && !primary_control_word[10] |=> !cmd.in_control &&
      $stable({cmd[26:5], cmd[3:0]}) && $stable(sol_error);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_inv;
    vq && bq |-> cmd.sp_invert == (cq && pq[11]);
  endproperty
  a_inv: assert property (p_inv) else $error("invert");
  property p_trq;
    vq && tq |-> cmd.rfg_active == pq[11] && cmd.brake_open == pq[12] &&
      cmd.torque_mode == pq[14] && cmd.rfg_bypass == (cq && sq[4]) &&
      cmd.int_inhibit == sq[6];
  endproperty
  a_trq: assert property (p_trq) else $error("torque");
  property p_pos;
    vq && oq |-> {cmd.task_reject, cmd.inter_stop, cmd.jog1, cmd.jog2,
      cmd.ref_start} == {!pq[4], !pq[5], pq[8], pq[9], pq[11]};
  endproperty
  a_pos: assert property (p_pos) else $error("position");
  property p_sec;
    vq && hq |-> cmd.endstop == sq[8] && cmd.sign_of_life == sq[15:12];
  endproperty
  a_sec: assert property (p_sec) else $error("secondary");
  property p_unk;
    word_valid && !kn |=> $stable(cmd) && $stable(sol_error);
  endproperty
  a_unk: assert property (p_unk) else $error("unknown");
  c_trq: cover property (vq && tq);
  c_pos: cover property (vq && oq);
  c_hold: cover property (word_valid && kn && !primary_control_word[10]);
endmodule // dcw_decoder_chk

bind dcw_decoder dcw_decoder_chk i_dcw_decoder_chk (.clk(clk),
  .rst_b(rst_b), .word_valid(word_valid), .telegram(telegram),
  .primary_control_word(primary_control_word),
  .secondary_control_word(secondary_control_word),
  .configuration_option_parameter(configuration_option_parameter),
  .cmd(cmd), .sol_error(sol_error));

//--- verif/dcw_ctrl_model.sv
// Purpose: Controller model sending cyclic control words
// Assumes: Bench requests settle just after a rising edge
// Notes:   Sign-of-life skips a count only when the bench asks
`timescale 1ns/1ps
module dcw_ctrl_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        skip,
  input  wire logic [7:0]  tg,
  input  wire logic [15:0] p,
  input  wire logic [15:0] s,
  output logic             word_valid,
  output logic [7:0]       telegram,
  output logic [15:0]      pcw,
  output logic [15:0]      scw
);
  logic [3:0] sol_q; // Master sign-of-life counter
  initial begin
    {word_valid, telegram, pcw, scw, sol_q} = '0;
  end
  // Launch one transfer per request on the falling edge
  always @(negedge clk) begin
    word_valid <= req;
    if (req) begin
      telegram <= tg;
      pcw      <= p;
      scw      <= {sol_q, s[11:0]};
      sol_q    <= sol_q + (skip ? 4'h2 : 4'h1);
    end else begin
      pcw <= ~pcw;  // Idle words invert every cycle
      scw <= ~scw;
    end
  end
endmodule // dcw_ctrl_model

//--- verif/tb_drive_control_word_decoder.sv
// Purpose: Self-checking bench for the control word decoder
// Assumes: Controller model drives the words, bench drives the rest
// Notes:   Corner words per telegram, then seeded random traffic
`timescale 1ns/1ps
module tb_drive_control_word_decoder;
  logic              clk, rst_b, req, skip, word_valid, sol_error, prev_ok;
  logic [7:0]        tg, telegram, t;
  logic [15:0]       p, s, cfg, pcw, scw, a, b;
  logic [31:0]       r;
  logic [3:0]        prev_sol;
  dcw_pkg::dcw_cmd_t cmd, exp_q;
  int                bad_count, tests_run, seed;
  logic [7:0] tgs [10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h66, 8'h69,
    8'h07, 8'h09, 8'h6e, 8'h6f};
  always #50 clk = ~clk;
  dcw_ctrl_model i_dcw_ctrl_model (.clk(clk), .req(req), .skip(skip),
    .tg(tg), .p(p), .s(s), .word_valid(word_valid), .telegram(telegram),
    .pcw(pcw), .scw(scw));
  dcw_decoder i_dcw_decoder (.clk(clk), .rst_b(rst_b),
    .word_valid(word_valid), .primary_control_word(pcw),
    .secondary_control_word(scw), .telegram(telegram),
    .configuration_option_parameter(cfg), .cmd(cmd),
    .sol_error(sol_error));
  // Group bits: basic, torque, positioning, secondary word
  function automatic logic [3:0] grp(logic [7:0] x);
    return {x inside {8'h01, 8'h02, 8'h03, 8'h05}, x inside {8'h66, 8'h69},
      x inside {8'h07, 8'h09, 8'h6e, 8'h6f}, !(x inside {8'h01, 8'h07})};
  endfunction
  // Expected commands after one update
  function automatic dcw_pkg::dcw_cmd_t calc(dcw_pkg::dcw_cmd_t o,
      logic [7:0] x, logic [15:0] w, logic [15:0] v, logic [15:0] c);
    logic [3:0] g;
    logic       sp;
    g = grp(x);
    sp = (g[3] || g[2]) && !(x inside {8'h05, 8'h69});
    if (g[3:1] == 3'h0) return o;
    o.in_control = 1'b0;
    if (!w[10]) return o;
    return '{pulse_allow: &w[3:0], ramp_stop: !w[0], coast_stop: !w[1],
      quick_stop: !w[2], op_inhibit: !w[3], switch_inhibit: !(w[1] && w[2]),
      rfg_out_zero: sp && !w[4], rfg_freeze: sp && !w[5],
      rfg_in_zero: sp && !w[6], fault_ack: w[7],
      sp_invert: g[3] && c[0] && w[11], rfg_active: g[2] && w[11],
      brake_open: g[2] && w[12], torque_mode: g[2] && w[14],
      rfg_bypass: g[2] && c[0] && v[4], int_inhibit: g[2] && v[6],
      task_reject: g[1] && !w[4], inter_stop: g[1] && !w[5],
      jog1: g[1] && w[8], jog2: g[1] && w[9], ref_start: g[1] && w[11],
      endstop: g[0] && v[8], in_control: 1'b1,
      sign_of_life: g[0] ? v[15:12] : 4'h0, default: 1'b0};
  endfunction
  task automatic cmp_cmd(dcw_pkg::dcw_cmd_t e, dcw_pkg::dcw_cmd_t q);
    tests_run++;
    if (q !== e) begin
      bad_count++;
      $display("[ERR] cmd expected %h seen %h", e, q);
    end
  endtask
  task automatic cmp_bit(logic e, logic q);
    tests_run++;
    if (q !== e) begin
      bad_count++;
      $display("[ERR] sol_error expected %b seen %b", e, q);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hold reset for 8 cycles and check the safe command set
  task automatic do_reset;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    exp_q = '{ramp_stop: 1, coast_stop: 1, switch_inhibit: 1, op_inhibit: 1,
      rfg_out_zero: 1, rfg_in_zero: 1, task_reject: 1, inter_stop: 1,
      default: 0};
    cmp_cmd(exp_q, cmd);
    cmp_bit(1'b0, sol_error);
    rst_b = 1'b1;
    prev_ok = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // One transfer through the model, checked after the taking edge
  task automatic send(logic [7:0] x, logic [15:0] w, logic [15:0] v,
      logic k, logic [15:0] c);
    logic [3:0] g;
    logic       e;
    {req, tg, p, s, skip} = {1'b1, x, w, v, k};
    @(negedge clk);
    cfg = c;
    @(posedge clk);
    #1;
    g = grp(telegram);
    exp_q = calc(exp_q, telegram, pcw, scw, cfg);
    cmp_cmd(exp_q, cmd);
    // Refused updates keep the sign-of-life reference
    if (g[3:1] != 3'h0 && pcw[10]) begin
      e = g[0] && prev_ok && scw[15:12] != prev_sol + 4'h1;
      cmp_bit(e, sol_error);
      prev_ok = g[0];
      prev_sol = scw[15:12];
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] run end expected before limit seen none");
    give_verdict();
  end
  initial begin
    {clk, rst_b, req, skip, tg, p, s, cfg, prev_ok} = '0;
    {bad_count, tests_run, exp_q, prev_sol} = '0;
    seed = 40533;
    do_reset();
    foreach (tgs[i]) begin
      send(tgs[i], 16'hffff, 16'hffff, 1'b0, 16'h0001);
      send(tgs[i], 16'h0400, 16'h0000, 1'b0, 16'h0000);
      send(tgs[i], 16'hfbff, 16'h0150, 1'b0, 16'h0001);
      send(8'h04, 16'h0000, 16'hffff, 1'b1, 16'h0001);
    end
    $display("Test corner words done");
    for (int n = 0; n < 300; n++) begin
      if (n == 150) begin
        req = 1'b0;
        do_reset();
      end
      r = $random(seed);
      a = $random(seed);
      b = $random(seed);
      a[10] = a[10] | (r[14:12] != 3'h0);
      t = (r[19:16] == 4'h0) ? r[31:24] : tgs[r[7:0] % 10];
      send(t, a, b, r[20] & r[21], r[23:8]);
    end
    $display("Test random traffic done");
    give_verdict();
  end
endmodule // tb_drive_control_word_decoder
